// [shared/pbmpg_pkg.sv]
// Register map, reset values and bus carrier for the port bank block
package pbmpg_pkg;
	// Plain-access offsets
	localparam logic [7:0] OFF_LATCH = 8'h00;
	localparam logic [7:0] OFF_PIN = 8'h10;
	localparam logic [7:0] OFF_SKIP = 8'h30;
	localparam logic [7:0] OFF_DRVMODE = 8'h40;
	localparam logic [7:0] OFF_STRENGTH = 8'h50;
	localparam logic [7:0] OFF_MVALUE = 8'h60;
	localparam logic [7:0] OFF_MENABLE = 8'h70;
	localparam logic [7:0] OFF_PGEN = 8'h80;
	localparam logic [7:0] OFF_PHASE = 8'h90;
	localparam logic [7:0] OFF_CTRL = 8'hA0;
	// Alias distances
	localparam logic [3:0] ALIAS_ALL = 4'h0;
	localparam logic [3:0] ALIAS_SET = 4'h4;
	localparam logic [3:0] ALIAS_CLEAR = 4'h8;
	localparam logic [3:0] ALIAS_MASKED = 4'hC;
	// Field positions
	localparam int PIN_W = 16;
	localparam int PG_W = 12;
	localparam int PH1_LSB = 16;
	localparam int PH0_LSB = 0;
	localparam int MASK_LSB = 16;
	// Reset values
	localparam logic [15:0] RST_LATCH = 16'hFFFF;
	localparam logic [15:0] RST_ZERO16 = 16'h0000;
	localparam logic [16:0] RST_STRENGTH = 17'h10000;
	localparam logic [11:0] RST_PGEN = 12'h000;
	localparam logic [11:0] RST_PH1 = 12'h000;
	localparam logic [11:0] RST_PH0 = 12'hFFF;
	localparam logic [31:0] RD_ZERO = 32'h0000_0000;

	// Register bus request
	typedef struct packed {
		logic [7:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} pbmpg_req_s;

	// Pulse generator phase
	typedef enum logic [1:0] {
		PG_IDLE = 2'b01,
		PG_FIRST = 2'b10
	} pbmpg_phase_e;
endpackage : pbmpg_pkg

// [logic/pbmpg_port_bank.sv]
// Port bank registers, port match qualification and pulse generator
//
// Function
// - Each match enable bit lets its pin take part in port match while global match is on.
// - An enabled pin raises a match event when its sensed level equals its match value bit.
// - Bits of unimplemented pins are reserved and have no function; the pulse enable bits are not masked to IMPL_PINS.
// - The pulse pin enable field is twelve bits, one per pin, resetting to zero.
// - The phase register holds the second-phase levels in bits 27 to 16, reset zero.
// - The phase register holds the first-phase levels in bits 11 to 0, reset all ones.
// - Any write to the phase register starts a new pulse on enabled pins.
// - At pulse start enabled pins take the written first-phase level at once.
// - On counter timeout enabled pins switch to the second-phase level and hold.
// - Set, clear and mask aliases lie 4, 8 and 12 bytes above the plain address.
// - Offsets are relative to the bank instance base.
// - Only listed aliases respond, except the latch, which takes writes at every offset of its block; pulse registers take plain access only.
// - A mask-alias write to the output latch uses the upper half as a write mask.
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/1ps
module pbmpg_port_bank #(
	parameter int IMPL_PINS = 16
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rst,
	// Register bus
	input wire pbmpg_pkg::pbmpg_req_s busReq,
	output logic [31:0] rdData,
	// Pins and match
	input wire logic [15:0] pinLevel,
	input wire logic pulseTimeout,
	output logic [15:0] pinOut,
	output logic [15:0] pinDriveMode,
	output logic [16:0] pinStrength,
	output logic [15:0] crossbarSkip,
	output logic portMatch
);
	wire [7:0] regBase = {busReq.addr[7:4], 4'h0};
	wire [3:0] aliasSel = busReq.addr[3:0];
	wire isAll = aliasSel == pbmpg_pkg::ALIAS_ALL;
	wire isSet = aliasSel == pbmpg_pkg::ALIAS_SET;
	wire isClear = aliasSel == pbmpg_pkg::ALIAS_CLEAR;
	wire isMasked = aliasSel == pbmpg_pkg::ALIAS_MASKED;
	wire [31:0] wd = busReq.wdata;
	wire wr = busReq.wr;
	wire [15:0] implMask = 16'(({17'h1} << IMPL_PINS) - 17'h1);

	logic [15:0] latch_q;
	logic [15:0] skip_q;
	logic [15:0] drvMode_q;
	logic [16:0] strength_q;
	logic [15:0] mValue_q;
	logic [15:0] mEnable_q;
	logic globalMatch_q;
	logic [11:0] pgEn_q;
	logic [11:0] ph0_q;
	logic [11:0] ph1_q;
	pbmpg_pkg::pbmpg_phase_e phase_q;
	pbmpg_pkg::pbmpg_phase_e phase_d;
	logic [11:0] pgLevel_q;
	logic [31:0] rdData_d;

	wire hitSc = isAll | isSet | isClear;
	wire wLatch = wr & (regBase == pbmpg_pkg::OFF_LATCH);
	wire wSkip = wr & (regBase == pbmpg_pkg::OFF_SKIP) & hitSc;
	wire wDrv = wr & (regBase == pbmpg_pkg::OFF_DRVMODE) & hitSc;
	wire wStr = wr & (regBase == pbmpg_pkg::OFF_STRENGTH) & hitSc;
	wire wMv = wr & (regBase == pbmpg_pkg::OFF_MVALUE) & hitSc;
	wire wMe = wr & (regBase == pbmpg_pkg::OFF_MENABLE) & hitSc;
	wire wCtrl = wr & (regBase == pbmpg_pkg::OFF_CTRL) & isAll;
	wire wPgen = wr & (regBase == pbmpg_pkg::OFF_PGEN) & isAll;
	wire wPhase = wr & (regBase == pbmpg_pkg::OFF_PHASE) & isAll;

	function automatic logic [16:0] merge(input logic [16:0] cur, input logic [16:0] val,
		input logic s, input logic c);
		merge = s ? (cur | val) : (c ? (cur & ~val) : val);
	endfunction : merge

	wire [15:0] keepBits = wd[pbmpg_pkg::MASK_LSB +: 16];
	wire [15:0] latchMasked = (latch_q & keepBits) | (wd[15:0] & ~keepBits);
	wire [15:0] latchScc = 16'(merge({1'b0, latch_q}, {1'b0, wd[15:0]}, isSet, isClear));
	wire [15:0] latchNew = isMasked ? latchMasked : latchScc;

	always_ff @(posedge clock) begin
		if (rst) begin
			latch_q <= pbmpg_pkg::RST_LATCH;
			skip_q <= pbmpg_pkg::RST_ZERO16;
			drvMode_q <= pbmpg_pkg::RST_ZERO16;
			strength_q <= pbmpg_pkg::RST_STRENGTH;
			mValue_q <= pbmpg_pkg::RST_ZERO16;
			mEnable_q <= pbmpg_pkg::RST_ZERO16;
			globalMatch_q <= 1'b0;
		end else begin
			if (wLatch)
				latch_q <= latchNew & implMask;
			if (wSkip)
				skip_q <= 16'(merge({1'b0, skip_q}, {1'b0, wd[15:0]}, isSet, isClear))
					& implMask;
			if (wDrv)
				drvMode_q <= 16'(merge({1'b0, drvMode_q}, {1'b0, wd[15:0]}, isSet, isClear))
					& implMask;
			if (wStr)
				strength_q <= merge(strength_q, wd[16:0], isSet, isClear) & {1'b1, implMask};
			if (wMv)
				mValue_q <= 16'(merge({1'b0, mValue_q}, {1'b0, wd[15:0]}, isSet, isClear))
					& implMask;
			if (wMe)
				mEnable_q <= 16'(merge({1'b0, mEnable_q}, {1'b0, wd[15:0]}, isSet, isClear))
					& implMask;
			if (wCtrl)
				globalMatch_q <= wd[0];
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			pgEn_q <= pbmpg_pkg::RST_PGEN;
			ph0_q <= pbmpg_pkg::RST_PH0;
			ph1_q <= pbmpg_pkg::RST_PH1;
		end else begin
			if (wPgen)
				pgEn_q <= wd[pbmpg_pkg::PG_W-1:0];
			if (wPhase) begin
				ph0_q <= wd[pbmpg_pkg::PH0_LSB +: pbmpg_pkg::PG_W];
				ph1_q <= wd[pbmpg_pkg::PH1_LSB +: pbmpg_pkg::PG_W];
			end
		end
	end

	// Phase tracking; a new write restarts even mid pulse
	always_comb begin
		phase_d = phase_q;
		case (phase_q)
			pbmpg_pkg::PG_IDLE: begin
				if (wPhase)
					phase_d = pbmpg_pkg::PG_FIRST;
			end
			pbmpg_pkg::PG_FIRST: begin
				if (!wPhase && pulseTimeout)
					phase_d = pbmpg_pkg::PG_IDLE;
			end
			default: phase_d = pbmpg_pkg::PG_IDLE;
		endcase
	end

	genvar g;
	generate
		for (g = 0; g < pbmpg_pkg::PG_W; g++) begin : gPulse
			always_ff @(posedge clock) begin
				if (rst)
					pgLevel_q[g] <= pbmpg_pkg::RST_PH0[g];
				else if (wPhase)
					pgLevel_q[g] <= wd[pbmpg_pkg::PH0_LSB + g];
				else if (phase_q == pbmpg_pkg::PG_FIRST && pulseTimeout)
					pgLevel_q[g] <= ph1_q[g];
			end
		end
	endgenerate

	always_ff @(posedge clock) begin
		if (rst)
			phase_q <= pbmpg_pkg::PG_IDLE;
		else
			phase_q <= phase_d;
	end

	// Pulse levels override the latch only on enabled pins
	wire [15:0] pulseMaskW = {4'h0, pgEn_q};
	wire [15:0] pulseLvlW = {4'h0, pgLevel_q};
	wire [15:0] pinOut_d = (latch_q & ~pulseMaskW) | (pulseLvlW & pulseMaskW);

	wire [15:0] pinHit = ~(pinLevel ^ mValue_q) & mEnable_q & implMask;
	wire portMatch_d = globalMatch_q & (|pinHit);

	// Read mux; set/clear aliases read the plain value
	always_comb begin
		rdData_d = pbmpg_pkg::RD_ZERO;
		case (regBase)
			pbmpg_pkg::OFF_LATCH: rdData_d = {16'h0000, latch_q};
			pbmpg_pkg::OFF_PIN: rdData_d = {16'h0000, pinLevel & implMask};
			pbmpg_pkg::OFF_SKIP: rdData_d = {16'h0000, skip_q};
			pbmpg_pkg::OFF_DRVMODE: rdData_d = {16'h0000, drvMode_q};
			pbmpg_pkg::OFF_STRENGTH: rdData_d = {15'h0000, strength_q};
			pbmpg_pkg::OFF_MVALUE: rdData_d = {16'h0000, mValue_q};
			pbmpg_pkg::OFF_MENABLE: rdData_d = {16'h0000, mEnable_q};
			pbmpg_pkg::OFF_PGEN: rdData_d = {20'h00000, pgEn_q};
			pbmpg_pkg::OFF_PHASE: rdData_d = {4'h0, ph1_q, 4'h0, ph0_q};
			pbmpg_pkg::OFF_CTRL: rdData_d = {30'h00000000, phase_q == pbmpg_pkg::PG_FIRST,
				globalMatch_q};
			default: rdData_d = pbmpg_pkg::RD_ZERO;
		endcase
	end

	// Outputs registered; read data only in the cycle after the strobe
	always_ff @(posedge clock) begin
		if (rst) begin
			rdData <= pbmpg_pkg::RD_ZERO;
			pinOut <= pbmpg_pkg::RST_LATCH;
			pinDriveMode <= pbmpg_pkg::RST_ZERO16;
			pinStrength <= pbmpg_pkg::RST_STRENGTH;
			crossbarSkip <= pbmpg_pkg::RST_ZERO16;
			portMatch <= 1'b0;
		end else begin
			rdData <= busReq.rd ? rdData_d : pbmpg_pkg::RD_ZERO;
			pinOut <= pinOut_d;
			pinDriveMode <= drvMode_q;
			pinStrength <= strength_q;
			crossbarSkip <= skip_q;
			portMatch <= portMatch_d;
		end
	end

	property p_phaseStart;
		@(posedge clock) disable iff (rst) wPhase |=> phase_q == pbmpg_pkg::PG_FIRST;
	endproperty
	a_phaseStart: assert property (p_phaseStart) else $error("pulse not started");

	property p_firstLevel;
		@(posedge clock) disable iff (rst)
			wPhase |=> ##1 (pinOut[11:0] & $past(pgEn_q)) == ($past(wd[11:0], 2) & $past(pgEn_q));
	endproperty
	a_firstLevel: assert property (p_firstLevel) else $error("first level wrong");

	property p_secondLevel;
		@(posedge clock) disable iff (rst)
			(phase_q == pbmpg_pkg::PG_FIRST && pulseTimeout && !wPhase) |=> pgLevel_q == ph1_q;
	endproperty
	a_secondLevel: assert property (p_secondLevel) else $error("second level wrong");

	property p_disabledPins;
		@(posedge clock) disable iff (rst)
			1'b1 |=> ((pinOut ^ $past(latch_q)) & ~$past(pulseMaskW)) == 16'h0000;
	endproperty
	a_disabledPins: assert property (p_disabledPins) else $error("disabled pin moved");

	property p_matchEvent;
		@(posedge clock) disable iff (rst) (globalMatch_q && |pinHit) |=> portMatch;
	endproperty
	a_matchEvent: assert property (p_matchEvent) else $error("match missed");

	property p_matchGate;
		@(posedge clock) disable iff (rst) (mEnable_q == 16'h0000 || !globalMatch_q) |=> !portMatch;
	endproperty
	a_matchGate: assert property (p_matchGate) else $error("spurious match");

	property p_setAlias;
		@(posedge clock) disable iff (rst)
			(wMe && isSet) |=> mEnable_q == (($past(mEnable_q) | $past(wd[15:0])) & implMask);
	endproperty
	a_setAlias: assert property (p_setAlias) else $error("set alias wrong");

	property p_maskedLatch;
		@(posedge clock) disable iff (rst)
			(wLatch && isMasked) |=> ((latch_q ^ $past(latch_q)) & $past(keepBits)) == 16'h0000;
	endproperty
	a_maskedLatch: assert property (p_maskedLatch) else $error("mask ignored");

	property p_plainOnly;
		@(posedge clock) disable iff (rst)
			(wr && regBase == pbmpg_pkg::OFF_PGEN && !isAll) |=> $stable(pgEn_q);
	endproperty
	a_plainOnly: assert property (p_plainOnly) else $error("alias accepted");

	property p_clearAlias;
		@(posedge clock) disable iff (rst)
			(wMe && isClear) |=> mEnable_q == ($past(mEnable_q) & ~$past(wd[15:0]));
	endproperty
	a_clearAlias: assert property (p_clearAlias) else $error("clear alias wrong");

	property p_maskRefused;
		@(posedge clock) disable iff (rst)
			(wr && regBase == pbmpg_pkg::OFF_MENABLE && isMasked) |=> $stable(mEnable_q);
	endproperty
	a_maskRefused: assert property (p_maskRefused) else $error("mask alias taken");

	property p_secondHold;
		@(posedge clock) disable iff (rst)
			(phase_q == pbmpg_pkg::PG_IDLE && !wPhase) |=> $stable(pgLevel_q);
	endproperty
	a_secondHold: assert property (p_secondHold) else $error("idle level moved");
endmodule : pbmpg_port_bank

// [tb/pbmpg_pin_model.sv]
// Package pin model: level sensed at each pin of the bank
`timescale 1ns/1ps
module pbmpg_pin_model (
	// Driven side
	input wire logic [15:0] pinOut,
	input wire logic [15:0] pinDriveMode,
	// Board side
	input wire logic [15:0] extLevel,
	output logic [15:0] pinLevel
);
	// Open drain only pulls low; the board decides the high level
	assign pinLevel = (pinDriveMode & pinOut) | (~pinDriveMode & pinOut & extLevel);
endmodule : pbmpg_pin_model

// [tb/port_bank_match_and_pulse_gen_tb_top.sv]
// Self-checking bench for the port bank block
`timescale 1ns/1ps
module port_bank_match_and_pulse_gen_tb_top;
	logic clock;
	logic rst;
	pbmpg_pkg::pbmpg_req_s busReq;
	logic [31:0] rdData;
	logic [15:0] pinLevel;
	logic [15:0] extLevel;
	logic pulseTimeout;
	logic [15:0] pinOut;
	logic [15:0] pinDriveMode;
	logic [16:0] pinStrength;
	logic [15:0] crossbarSkip;
	logic portMatch;
	int miscompares;
	int samplesChecked;

	pbmpg_port_bank #(.IMPL_PINS(16)) dut (.clock(clock), .rst(rst), .busReq(busReq),
		.rdData(rdData), .pinLevel(pinLevel), .pulseTimeout(pulseTimeout), .pinOut(pinOut),
		.pinDriveMode(pinDriveMode), .pinStrength(pinStrength), .crossbarSkip(crossbarSkip),
		.portMatch(portMatch));
	pbmpg_pin_model pins (.pinOut(pinOut), .pinDriveMode(pinDriveMode), .extLevel(extLevel),
		.pinLevel(pinLevel));

	initial begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] expv);
		samplesChecked++;
		if (seen !== expv) begin
			miscompares++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, expv);
		end
	endtask : check

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clock);
		busReq.wr <= 1'b0;
	endtask : wr

	// Read data stands only in the cycle after the strobe
	task automatic rdchk(input logic [7:0] a, input logic [31:0] expv);
		@(posedge clock);
		busReq <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
		@(posedge clock);
		busReq.rd <= 1'b0;
		#1;
		check(rdData, expv);
	endtask : rdchk

	task automatic settle;
		repeat (3) @(posedge clock);
		#1;
	endtask : settle

	task automatic t_reset;
		#1;
		check({16'h0, pinOut}, {16'h0, pbmpg_pkg::RST_LATCH});
		rdchk(pbmpg_pkg::OFF_PGEN, 32'h0000_0000);
		rdchk(pbmpg_pkg::OFF_PHASE, 32'h0000_0FFF);
	endtask : t_reset

	task automatic t_alias;
		wr(pbmpg_pkg::OFF_MENABLE, 32'h0000_00F0);
		rdchk(pbmpg_pkg::OFF_MENABLE, 32'h0000_00F0);
		wr(8'h74, 32'h0000_0003);
		rdchk(pbmpg_pkg::OFF_MENABLE, 32'h0000_00F3);
		wr(8'h78, 32'h0000_0030);
		rdchk(pbmpg_pkg::OFF_MENABLE, 32'h0000_00C3);
		wr(8'h7C, 32'h0000_FFFF);
		rdchk(pbmpg_pkg::OFF_MENABLE, 32'h0000_00C3);
		wr(8'h84, 32'h0000_0FFF);
		rdchk(pbmpg_pkg::OFF_PGEN, 32'h0000_0000);
		wr(8'h94, 32'h0000_0000);
		rdchk(pbmpg_pkg::OFF_PHASE, 32'h0000_0FFF);
		// every pin left out of matching
		wr(pbmpg_pkg::OFF_MENABLE, 32'h0000_0000);
	endtask : t_alias

	task automatic t_mask;
		wr(pbmpg_pkg::OFF_LATCH, 32'h0000_0000);
		wr(8'h0C, 32'hFF00_ABCD);
		rdchk(pbmpg_pkg::OFF_LATCH, 32'h0000_00CD);
		check({16'h0, pinOut}, 32'h0000_00CD);
	endtask : t_mask

	task automatic t_pulse;
		wr(pbmpg_pkg::OFF_PGEN, 32'h0000_000F);
		wr(pbmpg_pkg::OFF_PHASE, 32'h0ABC_0FA5);
		settle;
		check({16'h0, pinOut}, 32'h0000_00C5);
		rdchk(pbmpg_pkg::OFF_PHASE, 32'h0ABC_0FA5);
		rdchk(pbmpg_pkg::OFF_CTRL, 32'h0000_0002);
		@(posedge clock);
		pulseTimeout <= 1'b1;
		@(posedge clock);
		pulseTimeout <= 1'b0;
		settle;
		check({16'h0, pinOut}, 32'h0000_00CC);
		settle;
		check({16'h0, pinOut}, 32'h0000_00CC);
		rdchk(pbmpg_pkg::OFF_CTRL, 32'h0000_0000);
		// Second write restarts the first phase
		wr(pbmpg_pkg::OFF_PHASE, 32'h0ABC_0FA5);
		settle;
		check({16'h0, pinOut}, 32'h0000_00C5);
		// Restart while still in the first phase
		wr(pbmpg_pkg::OFF_PHASE, 32'h0000_0FAA);
		settle;
		check({16'h0, pinOut}, 32'h0000_00CA);
		wr(pbmpg_pkg::OFF_PGEN, 32'h0000_0000);
		settle;
		check({16'h0, pinOut}, 32'h0000_00CD);
	endtask : t_pulse

	task automatic t_match;
		// reserved upper bits written as zero
		wr(pbmpg_pkg::OFF_LATCH, 32'h0000_FFFF);
		wr(pbmpg_pkg::OFF_MVALUE, 32'h0000_0000);
		wr(pbmpg_pkg::OFF_MENABLE, 32'h0000_0001);
		wr(pbmpg_pkg::OFF_CTRL, 32'h0000_0001);
		settle;
		check({31'h0, portMatch}, 32'h0);
		@(posedge clock);
		extLevel <= 16'hFFFE;
		settle;
		check({31'h0, portMatch}, 32'h1);
		wr(pbmpg_pkg::OFF_MENABLE, 32'h0000_0002);
		settle;
		check({31'h0, portMatch}, 32'h0);
		wr(pbmpg_pkg::OFF_MENABLE, 32'h0000_0001);
		wr(pbmpg_pkg::OFF_CTRL, 32'h0000_0000);
		settle;
		check({31'h0, portMatch}, 32'h0);
	endtask : t_match

	// Drive mode, skip and strength copies reach the outputs
	task automatic t_config;
		check({15'h0, pinStrength}, 32'h0001_0000);
		rdchk(pbmpg_pkg::OFF_PIN, 32'h0000_FFFE);
		wr(8'h44, 32'h0000_0003);
		settle;
		check({16'h0, pinDriveMode}, 32'h0000_0003);
		rdchk(pbmpg_pkg::OFF_PIN, 32'h0000_FFFF);
		wr(8'h48, 32'h0000_0001);
		settle;
		check({16'h0, pinDriveMode}, 32'h0000_0002);
		wr(pbmpg_pkg::OFF_SKIP, 32'h0000_00FF);
		wr(8'h34, 32'h0000_0F00);
		wr(8'h38, 32'h0000_000F);
		rdchk(pbmpg_pkg::OFF_SKIP, 32'h0000_0FF0);
		check({16'h0, crossbarSkip}, 32'h0000_0FF0);
		wr(8'h58, 32'h0001_0000);
		wr(8'h54, 32'h0000_8001);
		rdchk(pbmpg_pkg::OFF_STRENGTH, 32'h0000_8001);
		check({15'h0, pinStrength}, 32'h0000_8001);
		wr(8'h3C, 32'h0000_FFFF);
		rdchk(pbmpg_pkg::OFF_SKIP, 32'h0000_0FF0);
	endtask : t_config

	task automatic conclude;
		$display("comparisons %0d mismatches %0d", samplesChecked, miscompares);
		if (miscompares == 0 && samplesChecked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : conclude

	// Whole run is about 150 cycles; generous margin
	initial begin
		repeat (3000) @(posedge clock);
		miscompares++;
		conclude;
	end

	initial begin
		busReq = '0;
		rst = 1'b1;
		pulseTimeout = 1'b0;
		extLevel = 16'hFFFF;
		miscompares = 0;
		samplesChecked = 0;
		repeat (16) @(posedge clock);
		rst <= 1'b0;
		t_reset;
		t_alias;
		t_mask;
		t_pulse;
		t_match;
		t_config;
		conclude;
	end
endmodule : port_bank_match_and_pulse_gen_tb_top
